// file: verilog/cmb_consts.vh
// Purpose: Constants for the combined flash/SRAM bus controller
// Assumes: 50 MHz mclk_i, 16-bit data bus, 20-bit word address
// Notes: Timing counts are derived from nanosecond figures
`ifndef CMB_CONSTS_VH
`define CMB_CONSTS_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CMB_CLK_NS 20
`define CMB_SETUP_NS 20
`define CMB_PULSE_NS 70
`define CMB_HOLD_NS 20
`define CMB_RST_NS 500
// Least times round up to whole cycles
`define CMB_CYC(ns) (((ns) + `CMB_CLK_NS - 1) / `CMB_CLK_NS)
`define CMB_SETUP_CYC `CMB_CYC(`CMB_SETUP_NS)
`define CMB_PULSE_CYC `CMB_CYC(`CMB_PULSE_NS)
`define CMB_HOLD_CYC `CMB_CYC(`CMB_HOLD_NS)
`define CMB_RST_CYC `CMB_CYC(`CMB_RST_NS)

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define CMB_AW 20
`define CMB_DW 16
`define CMB_SRAM_TOP_BIT 19
`define CMB_PROT_LIMIT 20'h00FFF
`define CMB_BLOCK_SHIFT 15

// ---------------------------------------------------------------
// Host command codes
// ---------------------------------------------------------------
`define CMB_OP_READ 2'h0
`define CMB_OP_WRITE 2'h1
`define CMB_OP_RESET 2'h2

`endif

// file: verilog/cmb_timer.v
// Purpose: Down counter that paces the phases of a bus cycle
// Assumes: load and count come from the same clock domain
// Notes: done_o is high in the cycle the count reaches zero
`timescale 1ns/1ps
module cmb_timer (
	input wire mclk_i,
	input wire reset_i,
	input wire load_i,
	input wire [7:0] count_i,
	output wire done_o
);
	reg [7:0] cnt_q;

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	// Loading takes priority so a new phase always restarts cleanly
	always @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_q <= 8'h00;
		end else if (load_i) begin
			cnt_q <= count_i;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// Done depends on the count alone: the caller derives load from done,
	// so gating done with load would close a combinational loop
	assign done_o = (cnt_q == 8'h00);
endmodule // cmb_timer

// file: verilog/cmb_host.v
// Purpose: Host-side controller driving a combined flash/SRAM package
// Assumes: Device pins are asynchronous; inputs are double synchronised
// Notes: One request at a time; busy_o is high while a cycle runs
`timescale 1ns/1ps
`include "cmb_consts.vh"
module cmb_host (
	input wire mclk_i,
	input wire reset_i,
	input wire req_i,
	input wire [1:0] op_i,
	input wire [`CMB_AW-1:0] addr_i,
	input wire [`CMB_DW-1:0] wdata_i,
	input wire [1:0] byte_en_i,
	input wire protect_i,
	output reg busy_o,
	output reg done_o,
	output reg [`CMB_DW-1:0] rdata_o,
	output reg prot_hit_o,
	output reg [4:0] block_o,
	output reg flash_ready_o,
	output reg [`CMB_AW-1:0] addr_o,
	output reg [`CMB_DW-1:0] data_o,
	output reg data_oe_o,
	input wire [`CMB_DW-1:0] data_i,
	output reg oe_n_o,
	output reg we_n_o,
	output reg sram_select_low_n_o,
	output reg sram_select_high_o,
	output reg flash_bank_select_n_o,
	output reg upper_lane_gate_n_o,
	output reg lower_lane_gate_n_o,
	output reg wp_n_o,
	output reg rst_n_o,
	input wire ready_busy_status_n_i
);
	localparam ST_IDLE = 3'd0;
	localparam ST_SETUP = 3'd1;
	localparam ST_PULSE = 3'd2;
	localparam ST_HOLD = 3'd3;
	localparam ST_RST = 3'd4;

	// Phase lengths in cycles, cut on purpose to the timer's width
	localparam [31:0] SETUP_LEN = `CMB_SETUP_CYC;
	localparam [31:0] PULSE_LEN = `CMB_PULSE_CYC;
	localparam [31:0] HOLD_LEN = `CMB_HOLD_CYC;
	localparam [31:0] RST_LEN = `CMB_RST_CYC;

	reg [2:0] state_q;
	reg is_sram_q;
	reg is_write_q;
	reg [`CMB_DW-1:0] din_s1_q;
	reg [`CMB_DW-1:0] din_s2_q;
	reg rb_s1_q;
	reg rb_s2_q;
	reg tmr_load;
	reg [7:0] tmr_count;
	wire tmr_done;

	// Region decode used for both selection and reporting
	function in_sram;
		input [`CMB_AW-1:0] a;
		in_sram = ~a[`CMB_SRAM_TOP_BIT];
	endfunction

	// ---------------------------------------------------------------
	// Phase timer
	// ---------------------------------------------------------------
	cmb_timer u_timer (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	// Read data and ready/busy come from pins: two flops for data, three for ready/busy
	always @(posedge mclk_i) begin
		if (reset_i) begin
			din_s1_q <= 16'h0000;
			din_s2_q <= 16'h0000;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
			flash_ready_o <= 1'b1;
		end else begin
			din_s1_q <= data_i;
			din_s2_q <= din_s1_q;
			rb_s1_q <= ready_busy_status_n_i;
			rb_s2_q <= rb_s1_q;
			flash_ready_o <= rb_s2_q;
		end
	end

	// ---------------------------------------------------------------
	// Timer load decode
	// ---------------------------------------------------------------
	always @* begin
		tmr_load = 1'b0;
		tmr_count = 8'h00;
		case (state_q)
			ST_IDLE: begin
				if (req_i && op_i == `CMB_OP_RESET) begin
					tmr_load = 1'b1;
					tmr_count = RST_LEN[7:0];
				end else if (req_i) begin
					tmr_load = 1'b1;
					tmr_count = SETUP_LEN[7:0];
				end
			end
			ST_SETUP: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = PULSE_LEN[7:0];
				end
			end
			ST_PULSE: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_count = HOLD_LEN[7:0];
				end
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Bus cycle sequencer
	// ---------------------------------------------------------------
	// Address and data are set up a full phase before any strobe so the
	// device sees them stable across the whole write interval
	always @(posedge mclk_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			is_sram_q <= 1'b0;
			is_write_q <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
			prot_hit_o <= 1'b0;
			block_o <= 5'h00;
			addr_o <= 20'h00000;
			data_o <= 16'h0000;
			data_oe_o <= 1'b0;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			sram_select_low_n_o <= 1'b1;
			sram_select_high_o <= 1'b0;
			flash_bank_select_n_o <= 1'b1;
			upper_lane_gate_n_o <= 1'b1;
			lower_lane_gate_n_o <= 1'b1;
			wp_n_o <= 1'b0;
			rst_n_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			wp_n_o <= ~protect_i;
			case (state_q)
				ST_IDLE: begin
					if (req_i && op_i == `CMB_OP_RESET) begin
						busy_o <= 1'b1;
						rst_n_o <= 1'b0;
						state_q <= ST_RST;
					end else if (req_i) begin
						busy_o <= 1'b1;
						is_sram_q <= in_sram(addr_i);
						is_write_q <= (op_i == `CMB_OP_WRITE);
						addr_o <= addr_i;
						block_o <= addr_i[`CMB_AW-1:`CMB_BLOCK_SHIFT];
						// Limit counts from the base of the flash half, as
						// the low half of the map always selects SRAM
						prot_hit_o <= ~in_sram(addr_i) &&
							({1'b0, addr_i[`CMB_AW-2:0]} <=
							`CMB_PROT_LIMIT);
						data_o <= wdata_i;
						// Host drives only while the device floats
						data_oe_o <= (op_i == `CMB_OP_WRITE);
						if (in_sram(addr_i)) begin
							sram_select_high_o <= 1'b1;
							lower_lane_gate_n_o <= ~byte_en_i[0];
							upper_lane_gate_n_o <= ~byte_en_i[1];
						end
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (tmr_done) begin
						if (is_sram_q) begin
							sram_select_low_n_o <= 1'b0;
						end else begin
							flash_bank_select_n_o <= 1'b0;
						end
						if (is_write_q) begin
							we_n_o <= 1'b0;
						end else begin
							oe_n_o <= 1'b0;
						end
						state_q <= ST_PULSE;
					end
				end
				ST_PULSE: begin
					if (tmr_done) begin
						// Write enable rises first: it is the capture edge,
						// selects follow so the interval ends on one edge
						we_n_o <= 1'b1;
						if (!is_write_q) begin
							rdata_o <= din_s2_q;
						end
						oe_n_o <= 1'b1;
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (tmr_done) begin
						// Data released after hold; flash keeps its own copy
						data_oe_o <= 1'b0;
						sram_select_low_n_o <= 1'b1;
						sram_select_high_o <= 1'b0;
						flash_bank_select_n_o <= 1'b1;
						upper_lane_gate_n_o <= 1'b1;
						lower_lane_gate_n_o <= 1'b1;
						busy_o <= 1'b0;
						done_o <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_RST: begin
					if (tmr_done) begin
						rst_n_o <= 1'b1;
						busy_o <= 1'b0;
						done_o <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // cmb_host

// file: verif/cmb_checker.sv
// Purpose: Pin checks on the flash/SRAM host
// Assumes: Strobes idle high between cycles
// Notes: Bound to every cmb_host
`timescale 1ns/1ps
module cmb_checker (
	input wire mclk_i, input wire reset_i, input wire protect_i,
	input wire busy_o, input wire done_o, input wire oe_n_o,
	input wire we_n_o, input wire rst_n_o, input wire wp_n_o,
	input wire data_oe_o, input wire [19:0] addr_o,
	input wire sram_select_low_n_o, input wire sram_select_high_o,
	input wire flash_bank_select_n_o, input wire upper_lane_gate_n_o,
	input wire lower_lane_gate_n_o
);
	// --------
	// Relations
	// --------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	rd_qual_a: assert property (!oe_n_o |-> we_n_o)
		else $error("read with write strobe low");
	bus_free_a: assert property (!oe_n_o |-> !data_oe_o)
		else $error("host drives during read");
	wr_qual_a: assert property ($fell(we_n_o) && !sram_select_low_n_o
		|-> sram_select_high_o && oe_n_o) else $error("bad write select");
	cap_edge_a: assert property ($rose(we_n_o) |-> $stable(addr_o)
		&& data_oe_o && (!sram_select_low_n_o || !flash_bank_select_n_o))
		else $error("selects released before write edge");
	wr_pulse_a: assert property ($fell(we_n_o) |-> !we_n_o [*5] ##1 we_n_o)
		else $error("write pulse length");
	one_bank_a: assert property (!(!flash_bank_select_n_o
		&& !sram_select_low_n_o && sram_select_high_o)) else $error("two banks");
	lane_idle_a: assert property (!flash_bank_select_n_o
		|-> upper_lane_gate_n_o && lower_lane_gate_n_o) else $error("flash lanes");
	wp_follow_a: assert property (!$past(reset_i)
		|-> wp_n_o == !$past(protect_i)) else $error("protect pin lag");
	rst_hold_a: assert property ($fell(rst_n_o) |-> !rst_n_o [*8])
		else $error("reset pulse short");
	idle_sel_a: assert property (!busy_o && !done_o |-> oe_n_o && we_n_o
		&& sram_select_low_n_o && !sram_select_high_o && flash_bank_select_n_o)
		else $error("idle pins not deselected");
endmodule // cmb_checker
bind cmb_host cmb_checker u_chk (.*);

// file: verif/cmb_dev_model.sv
// Purpose: Behavioural flash/SRAM package on the host pins
// Assumes: Open-drain status is pulled up outside
// Notes: Floating bus shows a toggling pattern
`timescale 1ns/1ps
module cmb_dev_model (
	input wire [19:0] a_i, input wire [15:0] d_i, input wire oe_n_i,
	input wire we_n_i, input wire s1_n_i, input wire s2_i, input wire f_n_i,
	input wire ub_n_i, input wire lb_n_i, input wire wp_n_i,
	input wire rst_n_i, output logic [15:0] q_o, output logic rb_low_o
);
	// --------
	// Storage and pins
	// --------
	logic [15:0] ms [int];
	logic [15:0] fl = 16'h0000, w, pat = 16'h5A3C, m;
	wire sram = !s1_n_i && s2_i && f_n_i;
	initial rb_low_o = 1'b0;
	always #10 pat = ~pat; // Undriven lanes never look stable
	// Write edge captures lanes; flash latches data
	always @(posedge we_n_i) begin
		if (sram) begin
			w = ms.exists(a_i[18:0]) ? ms[a_i[18:0]] : 16'h0000;
			if (!lb_n_i) w[7:0] = d_i[7:0];
			if (!ub_n_i) w[15:8] = d_i[15:8];
			ms[a_i[18:0]] = w;
		end else if (!f_n_i) begin
			fl = d_i;
			if (wp_n_i || a_i[18:0] > 19'h00FFF) begin
				rb_low_o <= 1'b1;
				rb_low_o <= #2000 1'b0;
			end
		end
	end
	always @(negedge rst_n_i) rb_low_o <= 1'b0;
	// Output gating by select, enable and lane
	always @* begin
		m = ms.exists(a_i[18:0]) ? ms[a_i[18:0]] : 16'h0000;
		q_o = pat;
		if (!oe_n_i && !f_n_i) q_o = fl;
		if (!oe_n_i && sram) q_o = {ub_n_i ? pat[15:8] : m[15:8],
			lb_n_i ? pat[7:0] : m[7:0]};
	end
endmodule // cmb_dev_model

// file: verif/tb_top.sv
// Purpose: Self-checking bench for cmb_host
// Assumes: Device model on the pins
// Notes: Reference memory kept in an array
`timescale 1ns/1ps
module tb_top;
	// --------
	// Signals
	// --------
	reg mclk_i = 0, reset_i = 1, req_i = 0, protect_i = 0;
	reg [1:0] op_i = 0, byte_en_i = 0;
	reg [19:0] addr_i = 0, wa;
	reg [15:0] wdata_i = 0, fd;
	reg [31:0] lf = 32'hAD37;
	reg [15:0] rm [int];
	integer num_errors = 0, n_tests = 0, i;
	wire busy_o, done_o, prot_hit_o, flash_ready_o, data_oe_o, oe_n_o, we_n_o;
	wire sram_select_low_n_o, sram_select_high_o, flash_bank_select_n_o;
	wire upper_lane_gate_n_o, lower_lane_gate_n_o, wp_n_o, rst_n_o, rb_low;
	wire [15:0] rdata_o, data_o, q;
	wire [19:0] addr_o;
	wire [4:0] block_o;
	wire [15:0] dq = data_oe_o ? data_o : q; // Shared bus level
	wire rb_n = rb_low ? 1'b0 : 1'b1; // Pull-up on status
	cmb_host dut (.*, .data_i(dq), .ready_busy_status_n_i(rb_n));
	cmb_dev_model u_dev (.a_i(addr_o), .d_i(dq), .oe_n_i(oe_n_o),
		.we_n_i(we_n_o), .s1_n_i(sram_select_low_n_o),
		.s2_i(sram_select_high_o), .f_n_i(flash_bank_select_n_o),
		.ub_n_i(upper_lane_gate_n_o), .lb_n_i(lower_lane_gate_n_o),
		.wp_n_i(wp_n_o), .rst_n_i(rst_n_o), .q_o(q), .rb_low_o(rb_low));
	always #10 mclk_i = ~mclk_i;
	// --------
	// Helpers
	// --------
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input string nm, input [15:0] e, input [15:0] s);
		n_tests++;
		if (e !== s) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One request, then a bounded wait for done on the falling edge
	task op(input [1:0] o, input [19:0] a, input [15:0] d, input [1:0] be);
		integer k;
		@(posedge mclk_i);
		op_i <= o; addr_i <= a; wdata_i <= d; byte_en_i <= be; req_i <= 1;
		@(posedge mclk_i);
		req_i <= 0;
		@(negedge mclk_i);
		chk("busy", 1, busy_o);
		k = 0;
		while (done_o !== 1'b1 && k < 100) begin
			@(negedge mclk_i);
			k++;
		end
		if (k == 100) chk("done", 1, 0);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		final_report;
	end
	// --------
	// Scenarios
	// --------
	initial begin
		repeat (20) @(posedge mclk_i);
		reset_i <= 0;
		for (i = 0; i < 12; i++) begin
			lf = lfsr(lf);
			wa = {1'b0, lf[0] ? 19'h7FFFF : {16'h0000, lf[3:1]}};
			if (!rm.exists(wa)) rm[wa] = 16'h0000;
			if (i[0]) rm[wa][7:0] = lf[23:16];
			if (i[1]) rm[wa][15:8] = lf[31:24];
			op(1, wa, lf[31:16], i[1:0]);
		end
		foreach (rm[k]) begin
			op(0, k[19:0], 0, 3);
			chk("sram word", rm[k], rdata_o);
			chk("block", k[19:15], block_o);
			op(0, k[19:0], 0, 1);
			chk("low lane", rm[k][7:0], rdata_o[7:0]);
		end
		$display("test sram done");
		fd = lf[15:0];
		op(1, 20'hC8000, fd, 3);
		repeat (5) @(negedge mclk_i);
		chk("ready busy", 0, flash_ready_o);
		op(2, 0, 0, 0);
		repeat (5) @(negedge mclk_i);
		chk("ready reset", 1, flash_ready_o);
		op(0, 20'hC8000, 0, 3);
		chk("flash word", fd, rdata_o);
		$display("test flash done");
		@(posedge mclk_i);
		protect_i <= 1;
		for (i = 0; i < 2; i++) begin
			op(1, 20'h80FFF + i, fd, 3);
			chk("prot hit", i == 0, prot_hit_o);
			repeat (5) @(negedge mclk_i);
			chk("protect", i == 0, flash_ready_o);
			repeat (120) @(negedge mclk_i);
			chk("ready end", 1, flash_ready_o);
		end
		$display("test protect done");
		final_report;
	end
endmodule // tb_top
